// ### core/wave_seq_pkg.sv
`default_nettype none
package wave_seq_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_TRIGGER    = 6'h0C;
  localparam logic [5:0] IDX_SLOT_FIRST = 6'h0F;
  localparam logic [5:0] IDX_SLOT_SIX   = 6'h14;
  localparam logic [5:0] IDX_SLOT_SEVEN = 6'h15;
  localparam logic [5:0] IDX_SLOT_LAST  = 6'h16;
  localparam logic [5:0] IDX_STATUS     = 6'h18;

  // Byte address bits that select a register word.
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // Slot layout: delay flag on top, identifier or delay count below.
  localparam int SLOT_W        = 8;
  localparam int SLOT_FLAG_BIT = 7;
  localparam int SLOT_VAL_W    = 7;
  localparam int SLOT_COUNT    = 8;
  localparam int SLOT_IDX_W    = 3;
  localparam logic [SLOT_W-1:0]     SLOT_RESET = 8'h00;
  localparam logic [SLOT_VAL_W-1:0] SLOT_STOP  = 7'h00;
  localparam logic [SLOT_IDX_W-1:0] SLOT_LAST  = 3'h7;

  // Trigger and status fields.
  localparam int TRIGGER_GO_BIT   = 0;
  localparam int STATUS_BUSY_BIT  = 0;
  localparam int STATUS_DELAY_BIT = 1;
  localparam int STATUS_SLOT_LSB  = 4;

  // Delay unit: 10 ms at a 10 MHz clock.
  localparam int DELAY_UNIT_MS     = 10;
  localparam int CLK_HZ            = 10_000_000;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * (CLK_HZ / 1000);
  localparam int TICK_CNT_W        = 24;

  // AHB transfer type that starts a transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : wave_seq_pkg
`default_nettype wire

// ### core/delay_timer.sv
`default_nettype none
// Counts a number of delay units and pulses done after the last one.
module delay_timer #(
  parameter int UNIT_CYCLES = wave_seq_pkg::DELAY_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  // Control.
  input  wire logic                                start,
  input  wire logic                                abort,
  input  wire logic [wave_seq_pkg::SLOT_VAL_W-1:0] units,
  // Result.
  output logic                                     running,
  output logic                                     done
);

  // Cycle count within one unit, and units left.
  logic [wave_seq_pkg::TICK_CNT_W-1:0] tick_ff;
  logic [wave_seq_pkg::SLOT_VAL_W-1:0] units_ff;
  logic                                running_ff;
  logic                                done_ff;

  // Last cycle of a unit, and last unit of the delay.
  wire unit_end = (tick_ff == wave_seq_pkg::TICK_CNT_W'(UNIT_CYCLES - 1));
  wire last_unit = (units_ff == wave_seq_pkg::SLOT_VAL_W'(1));

  // Abort wins over start so that a stopped sequence leaves no timer behind.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ff    <= '0;
      units_ff   <= '0;
      running_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else if (abort) begin
      running_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else if (start) begin
      tick_ff    <= '0;
      units_ff   <= units;
      running_ff <= (units != '0);
      done_ff    <= (units == '0);
    end else if (running_ff) begin
      tick_ff  <= unit_end ? '0 : tick_ff + 1'b1;
      units_ff <= unit_end ? units_ff - 1'b1 : units_ff;
      running_ff <= !(unit_end && last_unit);
      done_ff    <= unit_end && last_unit;
    end else begin
      done_ff <= 1'b0;
    end
  end

  assign running = running_ff;
  assign done    = done_ff;

endmodule : delay_timer
`default_nettype wire

// ### core/wave_sequencer.sv
// The AHB-Lite register port is this design's own decision.
`default_nettype none
module wave_sequencer #(
  parameter int DELAY_UNIT_CYCLES = wave_seq_pkg::DELAY_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Waveform playback engine.
  output logic             wave_start,
  output logic [6:0]       wave_id,
  input  wire logic        wave_done,
  // Sequencer state for the rest of the device.
  output logic             seq_busy,
  output logic             engine_idle
);

  // Bus side. The slave answers every transfer at once and always with OKAY,
  // so hreadyout is tied high. A write is captured in its address phase and
  // lands at the edge that ends its data phase. A read loads its data at the
  // edge that ends its address phase and holds it until the next read.
  // A read issued right behind a write to the same word therefore sees the
  // old value; software that reads back must leave one idle cycle between.

  // Playback side. A trigger write of one starts the walk at the first slot.
  // Each slot is looked at only when the walk reaches it, so software may
  // still edit slots that lie ahead of the walk. A fetched slot either ends
  // the walk, starts the delay timer or starts the engine with its identifier.
  // After a waveform reports done, or a delay runs out, the walk moves to the
  // next slot. It ends after the last slot in any case.

  // Limitation: a trigger write of zero drops the walk at once, but the engine
  // is not told. A waveform already under way keeps playing and its done pulse
  // is then ignored. A caller that needs a quiet stop must halt the engine too.

  // Timing: the engine sees its start pulse two cycles after the trigger is set,
  // and one cycle after each following fetch. The fetch cycle is the price of
  // reading the slot from the array rather than from a prefetched copy.

  // States. IDLE waits for the trigger. FETCH looks at the current slot for
  // one cycle. PLAY waits for the engine's done pulse. DELAY waits for the
  // timer. Every state falls back to IDLE when software clears the trigger.

  // Reset clears every slot, the trigger and the walk, so the engine sees no
  // request until software has written both a slot and the trigger.

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_PLAY,
    ST_DELAY
  } seq_state_e;

  // Slot storage, one entry per sequence position. Eight bytes are cheap
  // enough to keep in flops, which lets the walk read any slot at once.
  logic [wave_seq_pkg::SLOT_W-1:0] slots_ff [wave_seq_pkg::SLOT_COUNT];
  // Trigger bit; also shows whether playback is still running.
  logic                            go_ff;
  // Registered data-phase information of a write, and the read data. The write data phase needs the
  // address that the bus showed one cycle earlier.
  logic                            wr_pend_ff;
  logic [5:0]                      wr_idx_ff;
  logic [31:0]                     rdata_ff;
  // Sequencer state.
  seq_state_e                      state_ff;
  seq_state_e                      nxt_state;
  logic [wave_seq_pkg::SLOT_IDX_W-1:0] slot_ff;
  logic [wave_seq_pkg::SLOT_IDX_W-1:0] nxt_slot;
  logic                            wave_start_ff;
  logic [6:0]                      wave_id_ff;

  // Address phase decode. Only NONSEQ starts a transfer; the size is not
  // looked at because every register is one whole word.
  wire       addr_phase = hsel && hready && (htrans == wave_seq_pkg::HTRANS_NONSEQ);
  wire [5:0] addr_idx   = haddr[wave_seq_pkg::ADDR_MSB:wave_seq_pkg::ADDR_LSB];
  wire       rd_req     = addr_phase && !hwrite;
  wire       wr_req     = addr_phase && hwrite;

  // Write decode in the data phase. Writes to indices outside the map are
  // dropped without an error response.
  wire       wr_trigger = wr_pend_ff && (wr_idx_ff == wave_seq_pkg::IDX_TRIGGER);
  wire       wr_slot    = wr_pend_ff && (wr_idx_ff >= wave_seq_pkg::IDX_SLOT_FIRST)
                                     && (wr_idx_ff <= wave_seq_pkg::IDX_SLOT_LAST);
  wire [5:0] wr_off     = wr_idx_ff - wave_seq_pkg::IDX_SLOT_FIRST;
  wire [wave_seq_pkg::SLOT_IDX_W-1:0] wr_slot_idx = wr_off[wave_seq_pkg::SLOT_IDX_W-1:0];
  wire       go_write1  = wr_trigger && hwdata[wave_seq_pkg::TRIGGER_GO_BIT];
  wire       go_write0  = wr_trigger && !hwdata[wave_seq_pkg::TRIGGER_GO_BIT];

  // Read decode in the address phase. The slot offset is only meaningful
  // while the index lies inside the slot range.
  wire       rd_slot    = (addr_idx >= wave_seq_pkg::IDX_SLOT_FIRST)
                       && (addr_idx <= wave_seq_pkg::IDX_SLOT_LAST);
  wire [5:0] rd_off     = addr_idx - wave_seq_pkg::IDX_SLOT_FIRST;
  wire [wave_seq_pkg::SLOT_IDX_W-1:0] rd_slot_idx = rd_off[wave_seq_pkg::SLOT_IDX_W-1:0];

  // Named views of the two slots that sit at sequence_slot_six and sequence_slot_seven.
  // The walk indexes the array directly; these views give the two slots
  // their field names for anyone probing the block.
  wire [wave_seq_pkg::SLOT_W-1:0] sequence_slot_six   = slots_ff[5];
  wire [wave_seq_pkg::SLOT_W-1:0] sequence_slot_seven = slots_ff[6];
  wire       slot_six_delay_flag   = sequence_slot_six[wave_seq_pkg::SLOT_FLAG_BIT];
  wire [6:0] slot_six_entry        = sequence_slot_six[wave_seq_pkg::SLOT_VAL_W-1:0];
  wire       slot_seven_delay_flag = sequence_slot_seven[wave_seq_pkg::SLOT_FLAG_BIT];
  wire [6:0] slot_seven_entry      = sequence_slot_seven[wave_seq_pkg::SLOT_VAL_W-1:0];

  // Current slot fields as seen by the sequencer. A zero value stops the
  // walk whatever the delay flag says.
  wire [wave_seq_pkg::SLOT_W-1:0] cur_slot = slots_ff[slot_ff];
  wire       cur_delay = cur_slot[wave_seq_pkg::SLOT_FLAG_BIT];
  wire [6:0] cur_value = cur_slot[wave_seq_pkg::SLOT_VAL_W-1:0];
  wire       cur_stop  = (cur_value == wave_seq_pkg::SLOT_STOP);
  wire       last_slot = (slot_ff == wave_seq_pkg::SLOT_LAST);

  // Delay timer control. The timer starts in the fetch cycle of a delay
  // entry and is dropped by a trigger clear.
  wire       delay_start = (state_ff == ST_FETCH) && go_ff && !cur_stop && cur_delay;
  wire       delay_done;
  wire       delay_running;
  wire       abort       = go_write0;

  // Entry finished: a waveform reported done or a delay ran out.
  wire       entry_end   = ((state_ff == ST_PLAY) && wave_done)
                        || ((state_ff == ST_DELAY) && delay_done);
  // Sequence ends on a zero entry or after the eighth slot.
  wire       seq_end     = ((state_ff == ST_FETCH) && cur_stop)
                        || (entry_end && last_slot);

  // Start of a waveform: a fetched slot that is neither a stop nor a delay.
  // A clear of the trigger in the same cycle suppresses it.
  wire       play_start  = (state_ff == ST_FETCH) && !cur_stop && !cur_delay && !go_write0;
  // Delay bit of the status word.
  wire       delay_active = (state_ff == ST_DELAY);

  // Status word built from live sequencer state. Fields sit at the package's
  // bit positions and every other bit reads as zero.
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[wave_seq_pkg::STATUS_BUSY_BIT]  = go_ff;
    status_word[wave_seq_pkg::STATUS_DELAY_BIT] = delay_active;
    status_word[wave_seq_pkg::STATUS_SLOT_LSB +: wave_seq_pkg::SLOT_IDX_W] = slot_ff;
  end

  // Read data mux; unmapped indices read as zero. Slots fill the low byte
  // and their upper bits read as zero.
  wire [31:0] rd_mux =
      rd_slot                                  ? {24'h000000, slots_ff[rd_slot_idx]} :
      (addr_idx == wave_seq_pkg::IDX_TRIGGER)  ? {31'h00000000, go_ff} :
      (addr_idx == wave_seq_pkg::IDX_STATUS)   ? status_word :
                                                 32'h00000000;

  // Timer for delay entries. It keeps its own counters so that the state
  // machine only has to wait for its done pulse.
  delay_timer #(
    .UNIT_CYCLES (DELAY_UNIT_CYCLES)
  ) u_delay_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (delay_start),
    .abort   (abort),
    .units   (cur_value),
    .running (delay_running),
    .done    (delay_done)
  );

  // Capture the address phase of a write for use in its data phase.
  // The index follows the bus every cycle; only the pending flag qualifies it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 6'h00;
    end else begin
      wr_pend_ff <= wr_req;
      wr_idx_ff  <= addr_idx;
    end
  end

  // Read data is registered so it stands throughout the data phase.
  // It holds between reads, so idle cycles never disturb a value in flight.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_req) begin
      rdata_ff <= rd_mux;
    end
  end

  // Slot writes use only the low byte of the write data.
  // Slot writes; software may rewrite slots at any time, the sequencer
  // reads the slot when it reaches it, so late edits still take effect.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < wave_seq_pkg::SLOT_COUNT; i++) begin
        slots_ff[i] <= wave_seq_pkg::SLOT_RESET;
      end
    end else if (wr_slot) begin
      slots_ff[wr_slot_idx] <= hwdata[wave_seq_pkg::SLOT_W-1:0];
    end
  end

  // Trigger bit: a write of one sets it, the end of the sequence clears it.
  // A write of zero clears it as well and so aborts the walk.
  // A set in the same cycle as the end wins, so the new request is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_ff <= 1'b0;
    end else if (go_write1) begin
      go_ff <= 1'b1;
    end else if (go_write0 || seq_end) begin
      go_ff <= 1'b0;
    end
  end

  // Next state of the sequencer. The slot index only moves on the way from
  // a finished entry to the next fetch, or back to zero on a new trigger.
  always_comb begin
    nxt_state = state_ff;
    nxt_slot  = slot_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // A fresh trigger always starts at the first slot.
        if (go_ff) begin
          nxt_state = ST_FETCH;
          nxt_slot  = '0;
        end
      end
      ST_FETCH: begin
        // The slot is read here, at the moment the walk reaches it.
        if (cur_stop) begin
          nxt_state = ST_IDLE;
        end else if (cur_delay) begin
          nxt_state = ST_DELAY;
        end else begin
          nxt_state = ST_PLAY;
        end
      end
      ST_PLAY, ST_DELAY: begin
        // The engine's done pulse counts only while a waveform plays.
        if (entry_end) begin
          if (last_slot) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_FETCH;
            nxt_slot  = slot_ff + 1'b1;
          end
        end
      end
    endcase
    // Clearing the trigger abandons playback at once.
    if (go_write0) begin
      nxt_state = ST_IDLE;
    end
  end

  // Sequencer state registers. Both move together so that the fetch always
  // sees the slot index that belongs to it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      slot_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      slot_ff  <= nxt_slot;
    end
  end

  // Start pulse and identifier for the playback engine. The identifier moves
  // only with a start, so a stop entry or an abort leaves the last one shown.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_start_ff <= 1'b0;
      wave_id_ff    <= 7'h00;
    end else begin
      wave_start_ff <= play_start;
      // Load the identifier together with the start pulse.
      if (play_start) begin
        wave_id_ff <= cur_value;
      end
    end
  end

  // Bus answers: zero wait states, always OKAY.
  // Nothing in the map can be slow, so no wait state is ever needed.
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = rdata_ff;

  // Engine and state outputs.
  assign wave_start  = wave_start_ff;
  assign wave_id     = wave_id_ff;
  assign seq_busy    = go_ff;
  assign engine_idle = delay_running;

endmodule : wave_sequencer
`default_nettype wire

// ### testbench/wave_seq_sva.sv
`default_nettype none
// Watches the sequencer ports for playback ordering hazards.
module wave_seq_sva (
  // Clock and reset.
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus answer.
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Engine side and state.
  input wire logic       wave_start,
  input wire logic [6:0] wave_id,
  input wire logic       wave_done,
  input wire logic       seq_busy,
  input wire logic       engine_idle
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A stopped sequencer must never ask the engine to play.
  stop_quiet_a: assert property (!seq_busy |-> !wave_start)
    else $error("start while stopped");
  // Each request is a single pulse.
  start_pulse_a: assert property (wave_start |=> !wave_start)
    else $error("start longer than one cycle");
  // A zero entry stops the walk, so it is never played.
  id_nonzero_a: assert property (wave_start |-> wave_id != 7'h00)
    else $error("zero identifier played");
  // The identifier moves only together with a new request.
  id_hold_a: assert property ($changed(wave_id) |-> wave_start)
    else $error("identifier changed without start");
  // The engine idles during a timed wait.
  delay_quiet_a: assert property (engine_idle |-> !wave_start)
    else $error("start during delay");
  // A finished waveform leads to the next slot or to the stop.
  done_advance_a: assert property (wave_done && seq_busy && !engine_idle
    |-> ##[1:3] (wave_start || engine_idle || !seq_busy))
    else $error("no advance after done");
  // The slave never stretches or fails a transfer.
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
endmodule : wave_seq_sva
bind wave_sequencer wave_seq_sva u_sva (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .wave_start(wave_start), .wave_id(wave_id),
  .wave_done(wave_done), .seq_busy(seq_busy), .engine_idle(engine_idle));
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // A short delay unit keeps timed waits brief.
  localparam int UNIT = 4;
  logic        hclk, hresetn, hsel, hwrite, wave_done;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready, hreadyout, hresp, wave_start, seq_busy, engine_idle;
  wire logic [31:0] hrdata;
  wire logic [6:0]  wave_id;
  int          num_errors, total_checks, cycles;
  // The single slave drives the bus ready.
  assign hready = hreadyout;
  wave_sequencer #(.DELAY_UNIT_CYCLES(UNIT)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wave_start(wave_start), .wave_id(wave_id),
    .wave_done(wave_done), .seq_busy(seq_busy), .engine_idle(engine_idle));
  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // One single transfer; read data is taken at the edge ending the data phase.
  task automatic bus(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'h0};
    hwrite <= wr;
    htrans <= wave_seq_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Loads all slots, starts playback and plays the engine's part.
  task automatic run(input logic [7:0] s [8]);
    logic [31:0] rd;
    int n;
    for (int i = 0; i < 8; i++) begin
      bus(6'h0F + 6'(i), 1'b1, {24'h000000, s[i]}, rd);
    end
    bus(wave_seq_pkg::IDX_TRIGGER, 1'b1, 32'h1, rd);
    for (int i = 0; i < 8 && s[i][6:0] != 7'h00; i++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (wave_start !== 1'b1 && engine_idle !== 1'b1 && n < 20);
      chk({wave_start, engine_idle}, s[i][7] ? 2'b01 : 2'b10);
      if (s[i][7]) begin
        // Count the cycles the engine is held idle.
        n = 0;
        while (engine_idle === 1'b1 && n < 1000) begin
          @(posedge hclk);
          n++;
        end
        chk(32'(n), 32'(s[i][6:0]) * UNIT);
      end else begin
        chk(wave_id, s[i][6:0]);
        repeat (2) @(posedge hclk);
        wave_done <= 1'b1;
        @(posedge hclk);
        wave_done <= 1'b0;
      end
    end
    // The walk must end on its own within a few cycles.
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (seq_busy === 1'b1 && n < 20);
    chk(seq_busy, 1'b0);
    bus(wave_seq_pkg::IDX_TRIGGER, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
  endtask : run
  // Slot reset values, read back and an unmapped read.
  task automatic t_regs;
    logic [31:0] rd;
    bus(wave_seq_pkg::IDX_SLOT_SIX, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    bus(wave_seq_pkg::IDX_SLOT_SEVEN, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    bus(wave_seq_pkg::IDX_SLOT_SIX, 1'b1, 32'hFFFFFF95, rd);
    bus(wave_seq_pkg::IDX_SLOT_SIX, 1'b0, 32'h0, rd);
    chk(rd, 32'h95);
    bus(6'h3F, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    $display("regs test done");
  endtask : t_regs
  // All eight slots used, with delays in slot two and slot six.
  task automatic t_full;
    run('{8'h05, 8'h83, 8'h21, 8'h7F, 8'h01, 8'h82, 8'h22, 8'h33});
    $display("full test done");
  endtask : t_full
  // A zero in slot seven stops before the last slot.
  task automatic t_zero;
    run('{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h00, 8'h70});
    $display("zero stop test done");
  endtask : t_zero
  // Clearing the trigger during a delay drops the walk; status shows the delay.
  task automatic t_abort;
    logic [31:0] rd;
    int starts;
    bus(wave_seq_pkg::IDX_SLOT_FIRST, 1'b1, 32'h8A, rd);
    bus(wave_seq_pkg::IDX_SLOT_FIRST + 6'h01, 1'b1, 32'h15, rd);
    bus(wave_seq_pkg::IDX_TRIGGER, 1'b1, 32'h1, rd);
    repeat (3) @(posedge hclk);
    bus(wave_seq_pkg::IDX_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h3);
    bus(wave_seq_pkg::IDX_TRIGGER, 1'b1, 32'h0, rd);
    @(posedge hclk);
    chk({seq_busy, engine_idle}, 2'b00);
    starts = 0;
    repeat (60) begin
      @(posedge hclk);
      if (wave_start === 1'b1) begin
        starts++;
      end
    end
    chk(starts, 0);
    $display("abort test done");
  endtask : t_abort
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // Cuts a hang short well beyond the expected run length.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wave_done = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_full;
    t_zero;
    t_abort;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
